// file: logic/dci_cfg.svh
/*
  Constants for the DDR3 command and control input block: command codes,
  address bit positions, field widths.
  Assumes inclusion by bare name from the package and the checker.
*/
`ifndef DCI_CFG_SVH
`define DCI_CFG_SVH

`define DCI_BANKS          8
`define DCI_BA_W           3
`define DCI_ADDR_W         13
`define DCI_AP_BIT         10
`define DCI_BC_BIT         12
`define DCI_BYTE_W         8
`define DCI_LANES          2
`define DCI_CMD_W          4
`define DCI_CMD_MRS        4'h0
`define DCI_CMD_REF        4'h1
`define DCI_CMD_PRE        4'h2
`define DCI_CMD_ACT        4'h3
`define DCI_CMD_WR         4'h4
`define DCI_CMD_RD         4'h5
`define DCI_CMD_ZQ         4'h6
`define DCI_CMD_NOP        4'h7
`define DCI_DESEL_BIT      3
`define DCI_MR_ODT_OFF     1'h0

`endif

// file: logic/dci_pkg.sv
/*
  Types for the DDR3 command and control input block.
  Assumes dci_cfg.svh is reachable on the include path.
*/
`include "dci_cfg.svh"

package dci_pkg;

  typedef enum logic [1:0] {
    DCI_PWR_ACTIVE   = 2'b00,
    DCI_PWR_PRE_PD   = 2'b01,
    DCI_PWR_ACT_PD   = 2'b10,
    DCI_PWR_SELF_REF = 2'b11
  } dci_pwr_t;

  typedef logic [`DCI_CMD_W-1:0] dci_cmd_t;

endpackage

// file: logic/dci_mask_lane.sv
/*
  One write byte lane: applies the byte write mask on both strobe edges.
  Assumes rise and fall strobe samples arrive as one-cycle enables on clk.
*/
`timescale 1ns/10ps

module dci_mask_lane
  import dci_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // Lane inputs
  input  wire logic                   wr_active,
  input  wire logic                   strobe_rise,
  input  wire logic                   strobe_fall,
  input  wire logic [`DCI_BYTE_W-1:0] data_lines,
  input  wire logic                   write_mask,
  // Lane outputs
  output logic      [`DCI_BYTE_W-1:0] byte_out,
  output logic                        byte_valid
);

  logic [`DCI_BYTE_W-1:0] byte_q;
  logic                   valid_q;
  wire                    edge_hit = strobe_rise | strobe_fall;
  wire                    keep     = wr_active & edge_hit & ~write_mask;

  always_ff @(posedge clk) begin
    if (reset) begin
      byte_q  <= '0;
      valid_q <= 1'b0;
    end else begin
      valid_q <= keep;
      if (keep) begin
        byte_q <= data_lines;
      end
    end
  end

  assign byte_out   = byte_q;
  assign byte_valid = valid_q;

endmodule

// file: logic/dci_cmd_ctrl.sv
/*
  DDR3 command and control input logic: command capture and decode,
  clock-enable power states, input buffer gating, termination enable,
  byte write masks and bank address decode.
  Assumes clk stands for the rising crossing of the differential clock and
  all inputs are synchronous to it; reset_n is the device reset pin.
*/
// Summary of operation
// - Capture inputs on rising true clock edge.
// - Clock enable high runs clocks and buffers.
// - Low enable: idle powers down, open row active.
// - Self-refresh exit seen without the clock; the code leaves only at a clock edge with the enable high.
// - Power-down keeps only clock, termination, enable.
// - Self-refresh keeps only the clock enable.
// - Chip select high masks the command.
// - Select and strobes jointly encode command.
// - Registered termination high enables termination everywhere.
// - Ignore termination when disabled or self-refresh.
// - Masked write bytes are discarded.
// - Masks sampled on both strobe edges.
// - Bank bits pick bank or mode register.
// - Address bit ten: auto-precharge or all banks.
// - Address bit twelve low chops the burst.
// - Reset low clears state asynchronously; the byte lanes clear on the next clock.
`timescale 1ns/10ps

module dci_cmd_ctrl
  import dci_pkg::*;
(
  // Clock and resets
  input  wire logic                                 clk,
  input  wire logic                                 reset,
  input  wire logic                                 reset_n,
  // Command and address
  input  wire logic                                 clk_enable,
  input  wire logic                                 chip_select_n,
  input  wire logic                                 row_strobe_n,
  input  wire logic                                 col_strobe_n,
  input  wire logic                                 write_enable_n,
  input  wire logic [`DCI_BA_W-1:0]                 bank_addr,
  input  wire logic [`DCI_ADDR_W-1:0]               addr,
  input  wire logic                                 term_ctrl,
  // Configuration
  input  wire logic                                 mr_term_enable,
  input  wire logic                                 write_burst,
  // Write data lanes
  input  wire logic                                 lower_byte_strobe_rise,
  input  wire logic                                 lower_byte_strobe_fall,
  input  wire logic                                 upper_byte_strobe_rise,
  input  wire logic                                 upper_byte_strobe_fall,
  input  wire logic [`DCI_BYTE_W-1:0]               lower_byte_data_lines,
  input  wire logic [`DCI_BYTE_W-1:0]               upper_byte_data_lines,
  input  wire logic                                 lower_byte_write_mask,
  input  wire logic                                 upper_byte_write_mask,
  // Decoded command
  output dci_cmd_t                                  cmd_code,
  output logic                                      cmd_valid,
  output logic      [`DCI_BANKS-1:0]                cmd_bank_onehot,
  output logic                                      cmd_mode_reg_sel_valid,
  output logic                                      cmd_auto_precharge,
  output logic                                      cmd_precharge_all,
  output logic                                      cmd_burst_chop,
  output logic      [`DCI_ADDR_W-1:0]               cmd_addr,
  // Power and buffers
  output dci_pwr_t                                  pwr_state,
  output logic                                      internal_clk_run,
  output logic                                      cmd_buf_enable,
  output logic                                      term_buf_enable,
  output logic                                      out_drv_enable,
  output logic      [`DCI_BANKS-1:0]                open_rows,
  // Termination
  output logic                                      term_enable,
  // Write data out
  output logic      [`DCI_LANES*`DCI_BYTE_W-1:0]    wr_data,
  output logic      [`DCI_LANES-1:0]                wr_byte_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic [`DCI_BANKS-1:0] bank_dec(input logic [`DCI_BA_W-1:0] ba);
    bank_dec = `DCI_BANKS'(1) << ba;
  endfunction

  dci_pwr_t                pwr_q, pwr_d;
  logic [`DCI_BANKS-1:0]   rows_q, rows_d;
  logic                    cke_q;
  logic                    term_q;
  dci_cmd_t                cmd_q;
  logic                    cmd_v_q;
  logic [`DCI_BANKS-1:0]   bank_q;
  logic                    mrs_q, ap_q, pall_q, bc_q;
  logic [`DCI_ADDR_W-1:0]  addr_q;
  logic                    is_ref_entry_q;

  // Async reset pin plus the synchronous block reset
  wire      rst_any   = reset | ~reset_n;
  wire      in_self   = (pwr_q == DCI_PWR_SELF_REF);
  wire      in_pd     = (pwr_q == DCI_PWR_PRE_PD) | (pwr_q == DCI_PWR_ACT_PD);
  wire      running   = (pwr_q == DCI_PWR_ACTIVE);
  // Command inputs only listen while awake and selected
  wire      sel       = running & clk_enable & ~chip_select_n;
  wire      [`DCI_CMD_W-1:0] raw_cmd = {1'b0, row_strobe_n, col_strobe_n, write_enable_n};
  wire      [`DCI_BANKS-1:0] ba_hot = bank_dec(bank_addr);
  wire      is_act    = sel & (raw_cmd == `DCI_CMD_ACT);
  wire      is_pre    = sel & (raw_cmd == `DCI_CMD_PRE);
  wire      is_rd     = sel & (raw_cmd == `DCI_CMD_RD);
  wire      is_wr     = sel & (raw_cmd == `DCI_CMD_WR);
  wire      is_mrs    = sel & (raw_cmd == `DCI_CMD_MRS);
  wire      ap_bit    = addr[`DCI_AP_BIT];
  wire      bc_bit    = addr[`DCI_BC_BIT];
  wire      rw        = is_rd | is_wr;
  wire      all_idle  = (rows_q == '0);

  ////////////////////////////////////////////////////////////////////////////
  // Bank row tracking

  always_comb begin
    rows_d = rows_q;
    if (is_act) begin
      rows_d = rows_q | ba_hot;
    end
    if (is_pre) begin
      rows_d = ap_bit ? '0 : (rows_q & ~ba_hot);
    end
    if (rw & ap_bit) begin
      rows_d = rows_q & ~ba_hot;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state

  always_comb begin
    pwr_d = pwr_q;
    unique case (pwr_q)
      DCI_PWR_ACTIVE: begin
        if (!clk_enable) begin
          if (is_ref_entry_q) begin
            pwr_d = DCI_PWR_SELF_REF;
          end else if (all_idle) begin
            pwr_d = DCI_PWR_PRE_PD;
          end else begin
            pwr_d = DCI_PWR_ACT_PD;
          end
        end
      end
      DCI_PWR_PRE_PD, DCI_PWR_ACT_PD: begin
        if (clk_enable) begin
          pwr_d = DCI_PWR_ACTIVE;
        end
      end
      DCI_PWR_SELF_REF: begin
        // Level check, so no clocked edge of the enable is needed to leave
        if (clk_enable) begin
          pwr_d = DCI_PWR_ACTIVE;
        end
      end
    endcase
  end

  // A refresh issued with enable falling means self-refresh entry; decoded from the pins, as sel needs enable high
  wire  ref_entry = running & ~clk_enable & ~chip_select_n & (raw_cmd == `DCI_CMD_REF) & all_idle;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      is_ref_entry_q <= 1'b0;
    end else if (reset) begin
      is_ref_entry_q <= 1'b0;
    end else begin
      is_ref_entry_q <= ref_entry;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwr_q  <= DCI_PWR_ACTIVE;
      rows_q <= '0;
      cke_q  <= 1'b0;
      term_q <= 1'b0;
    end else if (reset) begin
      pwr_q  <= DCI_PWR_ACTIVE;
      rows_q <= '0;
      cke_q  <= 1'b0;
      term_q <= 1'b0;
    end else begin
      pwr_q  <= ref_entry ? DCI_PWR_SELF_REF : pwr_d;
      rows_q <= rows_d;
      cke_q  <= clk_enable;
      // Termination is only registered while its buffer is live
      term_q <= term_ctrl & mr_term_enable & ~in_self;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Captured command

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_q   <= `DCI_CMD_NOP;
      cmd_v_q <= 1'b0;
      bank_q  <= '0;
      mrs_q   <= 1'b0;
      ap_q    <= 1'b0;
      pall_q  <= 1'b0;
      bc_q    <= 1'b0;
      addr_q  <= '0;
    end else if (reset) begin
      cmd_q   <= `DCI_CMD_NOP;
      cmd_v_q <= 1'b0;
      bank_q  <= '0;
      mrs_q   <= 1'b0;
      ap_q    <= 1'b0;
      pall_q  <= 1'b0;
      bc_q    <= 1'b0;
      addr_q  <= '0;
    end else begin
      cmd_v_q <= sel;
      cmd_q   <= sel ? raw_cmd : `DCI_CMD_NOP;
      bank_q  <= ba_hot;
      mrs_q   <= is_mrs;
      ap_q    <= rw & ap_bit;
      pall_q  <= is_pre & ap_bit;
      bc_q    <= rw & ~bc_bit;
      addr_q  <= addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write byte lanes

  wire wr_active = running & write_burst & clk_enable;

  dci_mask_lane u_lane_lo (
    .clk         (clk),
    .reset       (rst_any),
    .wr_active   (wr_active),
    .strobe_rise (lower_byte_strobe_rise),
    .strobe_fall (lower_byte_strobe_fall),
    .data_lines  (lower_byte_data_lines),
    .write_mask  (lower_byte_write_mask),
    .byte_out    (wr_data[`DCI_BYTE_W-1:0]),
    .byte_valid  (wr_byte_valid[0])
  );

  dci_mask_lane u_lane_hi (
    .clk         (clk),
    .reset       (rst_any),
    .wr_active   (wr_active),
    .strobe_rise (upper_byte_strobe_rise),
    .strobe_fall (upper_byte_strobe_fall),
    .data_lines  (upper_byte_data_lines),
    .write_mask  (upper_byte_write_mask),
    .byte_out    (wr_data[`DCI_LANES*`DCI_BYTE_W-1:`DCI_BYTE_W]),
    .byte_valid  (wr_byte_valid[1])
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign cmd_code               = cmd_q;
  assign cmd_valid              = cmd_v_q;
  assign cmd_bank_onehot        = bank_q;
  assign cmd_mode_reg_sel_valid = mrs_q;
  assign cmd_auto_precharge     = ap_q;
  assign cmd_precharge_all      = pall_q;
  assign cmd_burst_chop         = bc_q;
  assign cmd_addr               = addr_q;
  assign pwr_state              = pwr_q;
  assign internal_clk_run       = running & cke_q;
  assign out_drv_enable         = running & cke_q;
  assign cmd_buf_enable         = running;
  assign term_buf_enable        = ~in_self;
  // Termination buffer stays live in power-down, so the registered value applies there too
  assign term_enable            = term_q;
  assign open_rows              = rows_q;

endmodule

// file: dv/dci_cmd_ctrl_props.sv
/*
  Checker for dci_cmd_ctrl: decode, power states, termination, byte masks.
  Assumes it is bound to the block and sees its ports only.
*/
`timescale 1ns/10ps
`include "dci_cfg.svh"

module dci_props
  import dci_pkg::*;
(
  // Clock and resets
  input wire logic                   clk,
  input wire logic                   reset,
  input wire logic                   reset_n,
  // Command inputs
  input wire logic                   clk_enable,
  input wire logic                   chip_select_n,
  input wire logic                   row_strobe_n,
  input wire logic                   col_strobe_n,
  input wire logic                   write_enable_n,
  input wire logic [`DCI_BA_W-1:0]   bank_addr,
  input wire logic                   term_ctrl,
  input wire logic                   mr_term_enable,
  // Write lanes
  input wire logic                   write_burst,
  input wire logic                   upper_byte_strobe_fall,
  input wire logic                   upper_byte_write_mask,
  // Outputs
  input wire dci_cmd_t               cmd_code,
  input wire logic                   cmd_valid,
  input wire logic [`DCI_BANKS-1:0]  cmd_bank_onehot,
  input wire dci_pwr_t               pwr_state,
  input wire logic                   cmd_buf_enable,
  input wire logic                   term_buf_enable,
  input wire logic [`DCI_BANKS-1:0]  open_rows,
  input wire logic                   term_enable,
  input wire logic [`DCI_LANES-1:0]  wr_byte_valid
);
  wire [2:0] rcw  = {row_strobe_n, col_strobe_n, write_enable_n};
  wire       take = pwr_state == DCI_PWR_ACTIVE && clk_enable && !chip_select_n;
  // A refresh with enable low and no open row goes to self-refresh, not power-down
  wire       sref = !chip_select_n && rcw == 3'h1;
  wire       idle = pwr_state == DCI_PWR_ACTIVE && !clk_enable && !sref;
  wire       live = mr_term_enable && pwr_state != DCI_PWR_SELF_REF;

  default clocking @(posedge clk); endclocking
  default disable iff (reset || !reset_n);

  sequence s_term_arm;
    (term_ctrl && live) ##1 live;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  desel_nop_a: assert property (chip_select_n |=> !cmd_valid && cmd_code == 4'h7)
    else $error("deselected cycle produced a command");
  cmd_decode_a: assert property (take && rcw != 3'h7 |=> cmd_valid && cmd_code == {1'h0, $past(rcw)})
    else $error("command code mismatch");
  bank_sel_a: assert property (take && rcw == 3'h3 |=> cmd_bank_onehot == (8'h01 << $past(bank_addr)))
    else $error("bank select mismatch");
  precharge_pd_a: assert property (idle && open_rows == 8'h00 |=> pwr_state == DCI_PWR_PRE_PD)
    else $error("no precharge power-down");
  active_pd_a: assert property (idle && open_rows != 8'h00 |=> pwr_state == DCI_PWR_ACT_PD)
    else $error("no active power-down");
  buf_gate_a: assert property (cmd_buf_enable == (pwr_state == DCI_PWR_ACTIVE)
    && term_buf_enable == (pwr_state != DCI_PWR_SELF_REF))
    else $error("input buffer gating wrong");
  sr_exit_a: assert property (pwr_state == DCI_PWR_SELF_REF && clk_enable |=> pwr_state == DCI_PWR_ACTIVE)
    else $error("self-refresh exit missed");
  term_on_a: assert property (s_term_arm |-> term_enable)
    else $error("termination not enabled");
  term_ign_a: assert property ((!live)[*2] |-> !term_enable)
    else $error("termination not ignored");
  mask_drop_a: assert property (write_burst && upper_byte_strobe_fall && upper_byte_write_mask
    |=> !wr_byte_valid[1])
    else $error("masked byte accepted");
endmodule

bind dci_cmd_ctrl dci_props u_props (.*);

// file: dv/dci_ctrl_model.sv
/*
  Controller model: drives command, address and termination pins.
  Assumes the bench owns the clock and calls the tasks.
*/
`timescale 1ns/10ps

module dci_ctrl_model (
  // Clock
  input  wire logic        clk,
  // Command pins
  output logic             clk_enable,
  output logic             chip_select_n,
  output logic             row_strobe_n,
  output logic             col_strobe_n,
  output logic             write_enable_n,
  output logic [2:0]       bank_addr,
  output logic [12:0]      addr,
  output logic             term_ctrl
);
  // Hot refresh interval in ns, half the normal spacing
  localparam int REFI_HOT_NS = 3900;
  localparam int CLK_NS      = 4;

  initial begin
    {clk_enable, chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} = 5'h1F;
    {bank_addr, addr, term_ctrl} = 17'h00000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Deselected slots invert the address rather than leave it stale
  task automatic slot(input logic cs_n, input logic cke, input logic [2:0] rcw,
                      input logic [2:0] ba, input logic [12:0] a);
    @(posedge clk);
    #1;
    chip_select_n = cs_n;
    {row_strobe_n, col_strobe_n, write_enable_n} = rcw;
    clk_enable = (!cs_n && rcw[2:1] == 2'h2) ? 1'h1 : cke;
    bank_addr = cs_n ? ~bank_addr : ba;
    addr = cs_n ? ~addr : a;
  endtask

  // One auto-refresh, then deselects until the hot interval runs out
  task automatic refresh_hot;
    slot(1'h0, 1'h1, 3'h1, 3'h0, 13'h0000);
    repeat (REFI_HOT_NS / CLK_NS - 1) slot(1'h1, 1'h1, 3'h7, 3'h0, 13'h0000);
  endtask

  task automatic mrs2(input logic asr);
    slot(1'h0, 1'h1, 3'h0, 3'h2, asr ? 13'h0040 : 13'h0080);
  endtask
endmodule

// file: dv/test_dci_cmd_ctrl.sv
/*
  Bench for dci_cmd_ctrl with the controller model.
  Assumes package, design, model and checker are compiled first.
*/
`timescale 1ns/10ps

module test_dci_cmd_ctrl;
  import dci_pkg::*;
  logic        clk, reset, reset_n, clk_enable, chip_select_n, row_strobe_n, col_strobe_n, write_enable_n;
  logic        term_ctrl, mr_term_enable, write_burst, cmd_valid, cmd_mode_reg_sel_valid, cmd_auto_precharge;
  logic        cmd_precharge_all, cmd_burst_chop, internal_clk_run, cmd_buf_enable, term_buf_enable;
  logic        out_drv_enable, term_enable, lower_byte_strobe_rise, lower_byte_strobe_fall;
  logic        upper_byte_strobe_rise, upper_byte_strobe_fall, lower_byte_write_mask, upper_byte_write_mask;
  logic [2:0]  bank_addr;
  logic [7:0]  cmd_bank_onehot, open_rows, lower_byte_data_lines, upper_byte_data_lines;
  logic [12:0] addr, cmd_addr;
  logic [15:0] wr_data;
  logic [1:0]  wr_byte_valid;
  dci_cmd_t    cmd_code;
  dci_pwr_t    pwr_state;
  int          miscompares, cmp_count, cycles;

  dci_cmd_ctrl dut (.*);
  dci_ctrl_model ctl (.*);

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic idle(input logic cke);
    ctl.slot(1'h1, cke, 3'h7, 3'h0, 13'h0000);
  endtask

  task automatic wait_active;
    for (int n = 0; n < 4 && pwr_state !== DCI_PWR_ACTIVE; n++) idle(1'h1);
    check(pwr_state, DCI_PWR_ACTIVE);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_decode;
    ctl.mrs2(1'h1);
    for (int i = 0; i < 7; i++) begin
      ctl.slot(1'h0, 1'h1, i[2:0], 3'h5, 13'h0400);
      idle(1'h1);
      check({cmd_valid, cmd_code, cmd_addr}, {1'h1, 1'h0, i[2:0], 13'h0400});
      if (i == 0) check(cmd_mode_reg_sel_valid, 1'h1);
      if (i == 3) check(open_rows, 8'h20);
      if (i inside {2, 4, 5}) check({cmd_bank_onehot, cmd_auto_precharge | cmd_precharge_all}, 9'h041);
      if (i inside {4, 5}) check(cmd_burst_chop, 1'h1);
    end
    check(open_rows, 8'h00);
  endtask

  task automatic t_desel;
    ctl.slot(1'h1, 1'h1, 3'h3, 3'h1, 13'h0000);
    ctl.slot(1'h0, 1'h1, 3'h2, 3'h0, 13'h0400);
    check({cmd_valid, cmd_code, open_rows}, 13'h0700);
    idle(1'h1);
    check({cmd_valid, cmd_code}, 5'h12);
  endtask

  task automatic t_power;
    idle(1'h0);
    idle(1'h0);
    check({pwr_state, cmd_buf_enable, term_buf_enable, internal_clk_run, out_drv_enable}, 6'h14);
    ctl.slot(1'h0, 1'h0, 3'h3, 3'h2, 13'h0000);
    idle(1'h1);
    check(cmd_valid, 1'h0);
    wait_active();
    ctl.slot(1'h0, 1'h1, 3'h3, 3'h2, 13'h0000);
    idle(1'h0);
    idle(1'h0);
    check(pwr_state, DCI_PWR_ACT_PD);
    wait_active();
    ctl.slot(1'h0, 1'h1, 3'h2, 3'h2, 13'h0000);
    idle(1'h1);
    check(open_rows, 8'h00);
  endtask

  task automatic t_selfref;
    mr_term_enable = 1'h1;
    ctl.term_ctrl = 1'h1;
    ctl.slot(1'h0, 1'h0, 3'h1, 3'h0, 13'h0000);
    idle(1'h0);
    idle(1'h0);
    check({pwr_state, term_buf_enable, term_enable}, 4'hC);
    idle(1'h1);
    idle(1'h1);
    check(pwr_state, DCI_PWR_ACTIVE);
    idle(1'h1);
    check(term_enable, 1'h1);
    mr_term_enable = 1'h0;
    idle(1'h1);
    idle(1'h1);
    check(term_enable, 1'h0);
    ctl.term_ctrl = 1'h0;
  endtask

  task automatic t_mask;
    write_burst = 1'h1;
    {lower_byte_strobe_rise, lower_byte_write_mask, lower_byte_data_lines} = 10'h2A5;
    {upper_byte_strobe_fall, upper_byte_write_mask, upper_byte_data_lines} = 10'h33C;
    @(posedge clk);
    #1;
    {lower_byte_strobe_rise, upper_byte_strobe_fall, lower_byte_strobe_fall, upper_byte_strobe_rise} = 4'h3;
    {lower_byte_write_mask, upper_byte_write_mask, upper_byte_data_lines} = 10'h25A;
    check({wr_byte_valid, wr_data[7:0]}, 10'h1A5);
    @(posedge clk);
    #1;
    {lower_byte_strobe_fall, upper_byte_strobe_rise, write_burst} = 3'h0;
    check({wr_byte_valid, wr_data[15:8]}, 10'h25A);
  endtask

  task automatic t_reset;
    ctl.slot(1'h0, 1'h1, 3'h3, 3'h1, 13'h0000);
    idle(1'h1);
    check(open_rows, 8'h02);
    #1 reset_n = 1'h0;
    #1 check(open_rows, 8'h00);
    @(posedge clk);
    #1 reset_n = 1'h1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Ceiling is well above the thousand or so cycles the scenarios need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    {reset, reset_n, mr_term_enable, write_burst} = 4'hC;
    {lower_byte_strobe_rise, lower_byte_strobe_fall, upper_byte_strobe_rise, upper_byte_strobe_fall} = 4'h0;
    {lower_byte_write_mask, upper_byte_write_mask, lower_byte_data_lines, upper_byte_data_lines} = 18'h00000;
    {miscompares, cmp_count, cycles} = '0;
    repeat (16) @(posedge clk);
    #1 reset = 1'h0;
    check({cmd_valid, cmd_code, pwr_state, open_rows, term_enable}, 16'h3800);
    t_decode();
    t_desel();
    t_power();
    t_selfref();
    t_mask();
    t_reset();
    ctl.refresh_hot();
    check({pwr_state, open_rows}, 10'h000);
    idle(1'h1);
    print_verdict();
  end
endmodule
